//--- emb_bus_checker.sv
// Concurrent checks on the module control bus between both ends.
// Assumes both ends share clock and rst.
`timescale 1ns/10ps
module emb_bus_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [3:0] moduleAddress,
  input wire logic       busClock,
  input wire logic       serialData,
  input wire logic       writeCmd,
  input wire logic       readCmd,
  input wire logic       returnOut,
  input wire logic       returnOe
);
  logic [7:0] riseCount;
  logic       busClockQ;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Count restarts on any command, so reads never leak into a write frame
  always_ff @(posedge clock) begin
    busClockQ <= busClock;
    if (rst || writeCmd || readCmd)
      riseCount <= 8'h00;
    else if (busClock && !busClockQ)
      riseCount <= riseCount + 8'h01;
  end

  frame_count_a: assert property ($rose(writeCmd) |-> riseCount == 8'h20)
    else $error("write command without 32 clock rises");
  clock_still_a: assert property (writeCmd |-> $stable(busClock))
    else $error("bus clock moved during write command");
  addr_held_a: assert property (writeCmd && $past(writeCmd) |-> $stable(moduleAddress))
    else $error("address moved during write command");
  write_pulse_a: assert property ($rose(writeCmd) |-> ##[1:1000] !writeCmd)
    else $error("write command not a short pulse");
  return_cause_a: assert property ($rose(returnOe) |->
                                   $past(readCmd, 2) && $past(moduleAddress, 2) == emb_pkg::ADDR_EXCITER)
    else $error("return line driven without exciter read");
  gain_noread_a: assert property ($rose(readCmd) && moduleAddress == emb_pkg::ADDR_GAIN |-> !returnOe [*8])
    else $error("return line driven for gain address");
  read_drive_a: assert property ($rose(readCmd) && moduleAddress == emb_pkg::ADDR_EXCITER |-> ##[1:8] returnOe)
    else $error("exciter read did not drive return line");
  return_release_a: assert property ($fell(readCmd) |-> ##[0:8] !returnOe)
    else $error("return line not released after read");
  clock_half_a: assert property ($rose(busClock) |-> busClock [*8])
    else $error("bus clock high phase too short");
endmodule

//--- emb_bus_if.sv
// Module control bus between the controller and the exciter slave.
// The controller resolves the shared return line from its enable.
`timescale 1ns/10ps
interface emb_bus_if;
  logic [3:0] moduleAddress;
  logic       busClock;
  logic       serialData;
  logic       writeCmd;
  logic       readCmd;
  logic       returnOut;
  logic       returnOe;
  modport controller (output moduleAddress, output busClock, output serialData,
                      output writeCmd, output readCmd, input returnOut, input returnOe);
  modport exciter (input moduleAddress, input busClock, input serialData,
                   input writeCmd, input readCmd, output returnOut, output returnOe);
endinterface

//--- emb_controller.sv
// Controller end: shifts a 32-bit frame, then strobes write, or
// strobes read and collects the status word.
// Assumes the return line arrives asynchronously.
`timescale 1ns/10ps
module emb_controller (
  input  wire logic                            clock,
  input  wire logic                            rst,
  emb_bus_if.controller                        bus,
  input  wire logic                            writeReq,
  input  wire logic                            readReq,
  input  wire logic [3:0]                      targetAddress,
  input  wire logic [emb_pkg::FRAME_BITS-1:0]  frameIn,
  output logic                                 busy,
  output logic                                 readDone,
  output logic [emb_pkg::STATUS_BITS-1:0]      statusWord,
  output logic                                 loopBackOk
);
  typedef enum logic [2:0] {IDLE, SHIFT, STROBE, READ, DONE} emb_state_t;
  emb_state_t state;
  logic [emb_pkg::FRAME_BITS-1:0] frame;
  logic [7:0]  halfCount;
  logic [6:0]  edgeCount;
  logic        isRead, retMeta, retSync;
  wire halfTick = halfCount == 8'(emb_pkg::LINK_HALF_CYC - 1);

  always_ff @(posedge clock) begin
    retMeta <= bus.returnOut & bus.returnOe;
    retSync <= retMeta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state             <= IDLE;
      bus.busClock      <= 1'b0;
      bus.serialData    <= 1'b0;
      bus.moduleAddress <= emb_pkg::ADDR_IDLE;
      bus.writeCmd      <= 1'b0;
      bus.readCmd       <= 1'b0;
      halfCount         <= 8'h00;
      edgeCount         <= 7'h00;
      frame             <= '0;
      isRead            <= 1'b0;
      busy              <= 1'b0;
      readDone          <= 1'b0;
      statusWord        <= '0;
      loopBackOk        <= 1'b0;
    end else begin
      readDone  <= 1'b0;
      halfCount <= halfTick ? 8'h00 : halfCount + 8'h01;
      unique case (state)
        IDLE: begin
          halfCount <= 8'h00;
          edgeCount <= 7'h00;
          if (writeReq) begin
            state          <= SHIFT;
            busy           <= 1'b1;
            isRead         <= 1'b0;
            frame          <= frameIn;
            bus.serialData <= frameIn[emb_pkg::FRAME_BITS-1]; // R7
          end else if (readReq) begin
            state  <= STROBE;
            busy   <= 1'b1;
            isRead <= 1'b1;
          end
        end
        SHIFT: if (halfTick) begin
          // Exactly 32 rising edges, MSB (loop-back) first
          bus.busClock <= ~bus.busClock; // R5
          edgeCount <= edgeCount + 7'h01;
          if (bus.busClock) begin
            frame <= {frame[emb_pkg::FRAME_BITS-2:0], 1'b0};
            bus.serialData <= frame[emb_pkg::FRAME_BITS-2];
          end
          if (edgeCount == 7'(2 * emb_pkg::FRAME_BITS - 1)) begin
            state     <= STROBE;
            edgeCount <= 7'h00;
          end
        end
        STROBE: if (halfTick) begin
          // Address first, command a half period later
          bus.moduleAddress <= targetAddress; // R6
          edgeCount <= edgeCount + 7'h01;
          if (edgeCount == 7'h01) begin
            bus.writeCmd <= ~isRead;
            bus.readCmd  <= isRead;
          end
          if (edgeCount == 7'(emb_pkg::STROBE_CYC)) begin
            bus.writeCmd <= 1'b0;
            edgeCount    <= 7'h00;
            state <= isRead ? READ : DONE;
          end
        end
        READ: if (halfTick) begin
          bus.busClock <= ~bus.busClock;
          edgeCount <= edgeCount + 7'h01;
          if (!bus.busClock) begin
            statusWord <= {statusWord[emb_pkg::STATUS_BITS-2:0], retSync};
          end
          if (edgeCount == 7'(2 * emb_pkg::STATUS_BITS - 1)) begin
            state <= DONE;
          end
        end
        DONE: begin
          bus.readCmd  <= 1'b0;
          bus.busClock <= 1'b0;
          bus.moduleAddress <= emb_pkg::ADDR_IDLE;
          loopBackOk <= isRead ? statusWord[0] : loopBackOk; // R8
          readDone <= isRead;
          busy     <= 1'b0;
          state    <= IDLE;
        end
      endcase
    end
  end
endmodule

//--- emb_exciter.sv
// Exciter end of the module control bus: address decode, command shift
// latches, status readback shifter, gain-control forwarding.
// Assumes all bus pins are asynchronous to clock.
`timescale 1ns/10ps
// Operation
// R1: Decode address 5 as exciter module
// R2: Same decoder also serves gain-control address 9
// R3: Write, read and gain-write are short pulses
// R4: No gain-control read; status rides readback word
// R5: Thirty-two clock pulses shift the command frame
// R6: Write strobe copies shift bits to outputs
// R7: First bit in lands in the final position
// R8: Controller checks loop-back bit during self test
// R9: Read strobe loads status, then shifts out
// R10: Return line driven only during read strobe
// R11: Bus clock buffered, always enabled, toward module
// R12: Outputs disabled about 400 ms after power-up
// R13: Forward strobe, clock, data to gain module
// R14: One bit selects meter path source
// R15: Off-board command bits routed out directly
// R16: Outputs hold until next exciter write strobe
module emb_exciter #(
  parameter int POWERUP_CYCLES = emb_pkg::POWERUP_CYC
) (
  input  wire logic                            clock,
  input  wire logic                            rst,
  emb_bus_if.exciter                           bus,
  input  wire logic [emb_pkg::STATUS_BITS-1:0] statusIn,
  output logic [emb_pkg::FRAME_BITS-1:0]       commandOut,
  output logic                                 outputEnable,
  output logic                                 meterPathSelect,
  output logic                                 keyedModeLine,
  output logic                                 lpfBypass,
  output logic [2:0]                           lpfBandSelect,
  output logic                                 lpfTestEnable,
  output logic                                 loopBackBit,
  output logic                                 gainWriteStrobe,
  output logic                                 gainClock,
  output logic                                 gainData
);
  localparam int FB = emb_pkg::FRAME_BITS;
  localparam int SB = emb_pkg::STATUS_BITS;

  logic [3:0]    addrMeta;
  logic [3:0]    addrSync;
  logic [2:0]    ctlMeta;
  logic [2:0]    ctlSync;
  logic [2:0]    ctlLast;
  logic          clkSync;
  logic          clkLast;
  logic          dataMeta;
  logic          dataSync;
  // Status inputs come from other boards, so they are synchronised too
  logic [SB-1:0] statusMeta;
  logic [SB-1:0] statusSync;
  logic [FB-1:0] shiftReg;
  logic [SB-1:0] statusReg;
  logic [31:0]   powerCount;
  logic          readActive;

  // Synchronise every pin before it is looked at
  always_ff @(posedge clock) begin
    addrMeta <= bus.moduleAddress;
    addrSync <= addrMeta;
    ctlMeta  <= {bus.writeCmd, bus.readCmd, bus.busClock};
    ctlSync  <= ctlMeta;
    ctlLast  <= ctlSync;
    dataMeta <= bus.serialData;
    dataSync <= dataMeta;
  end

  always_ff @(posedge clock) begin
    statusMeta <= statusIn;
    statusSync <= statusMeta;
  end

  // One decoder serves both module addresses
  function automatic logic moduleHit(input logic [3:0] addr, input logic [3:0] code);
    return addr == code;
  endfunction
  assign clkSync = ctlSync[0];
  assign clkLast = ctlLast[0];

  wire isExciter  = moduleHit(addrSync, emb_pkg::ADDR_EXCITER); // R1
  wire isGain     = moduleHit(addrSync, emb_pkg::ADDR_GAIN);    // R2
  wire writeRise  = ctlSync[2] & ~ctlLast[2];
  wire readRise   = ctlSync[1] & ~ctlLast[1];
  wire readLevel  = ctlSync[1] & isExciter;
  wire clockRise  = clkSync & ~clkLast;
  wire clockFall  = ~clkSync & clkLast;
  // One-cycle strobes from command edges, never levels
  wire excWrite   = writeRise & isExciter;             // R3
  wire excRead    = readRise & isExciter;              // R3
  wire gainWrite  = writeRise & isGain;                // R3 R4
  wire powerDone  = powerCount >= 32'(POWERUP_CYCLES);
  wire [FB-1:0] nextCommand = shiftReg;

  // First bit in ends at the top after 32 shifts
  always_ff @(posedge clock) begin
    if (rst) begin
      shiftReg <= emb_pkg::CMD_RESET;
    end else if (clockRise && !readActive) begin
      shiftReg <= {shiftReg[FB-2:0], dataSync}; // R5 R7
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      commandOut <= emb_pkg::CMD_RESET;
    end else if (excWrite) begin
      commandOut <= nextCommand; // R6 R16
    end
  end

  // Power-up hold-off counted from reset release
  always_ff @(posedge clock) begin
    if (rst) begin
      powerCount   <= 32'h0000_0000;
      outputEnable <= 1'b0;
    end else begin
      if (!powerDone) begin
        powerCount <= powerCount + 32'h0000_0001;
      end
      outputEnable <= powerDone; // R12
    end
  end

  // Outputs read zero until enabled, so no random data shows
  always_ff @(posedge clock) begin
    if (rst) begin
      meterPathSelect <= 1'b0;
      keyedModeLine   <= 1'b0;
      lpfBypass       <= 1'b0;
      lpfBandSelect   <= 3'h0;
      lpfTestEnable   <= 1'b0;
      loopBackBit     <= 1'b0;
    end else begin
      meterPathSelect <= outputEnable & commandOut[emb_pkg::METER_SEL_POS];  // R14
      keyedModeLine   <= outputEnable & commandOut[emb_pkg::KEYED_MODE_POS]; // R15
      lpfBypass       <= outputEnable & commandOut[emb_pkg::LPF_BYPASS_POS]; // R15
      lpfBandSelect   <= {3{outputEnable}} & commandOut[emb_pkg::LPF_BAND_HI:emb_pkg::LPF_BAND_LO]; // R15
      lpfTestEnable   <= outputEnable & commandOut[emb_pkg::LPF_TEST_POS];   // R15
      loopBackBit     <= outputEnable & commandOut[emb_pkg::LOOPBACK_POS];   // R7 R15
    end
  end

  // Status load on read strobe, shift on each falling bus edge while the exciter read is active
  always_ff @(posedge clock) begin
    if (rst) begin
      statusReg  <= '0;
      readActive <= 1'b0;
    end else begin
      readActive <= readLevel;
      if (excRead) begin
        statusReg <= statusSync; // R9 R4
      end else if (readActive && clockFall) begin
        statusReg <= {statusReg[SB-2:0], 1'b0}; // R9
      end
    end
  end

  // Return line driver, enabled only while the exciter read is active
  always_ff @(posedge clock) begin
    if (rst) begin
      bus.returnOut <= 1'b0;
      bus.returnOe  <= 1'b0;
    end else begin
      bus.returnOut <= statusReg[SB-1];
      bus.returnOe  <= readActive;   // R10
    end
  end

  // Gain module is write-only: strobe, clock and data only
  always_ff @(posedge clock) begin
    if (rst) begin
      gainWriteStrobe <= 1'b0;
      gainClock       <= 1'b0;
      gainData        <= 1'b0;
    end else begin
      gainWriteStrobe <= gainWrite;    // R13
      gainClock       <= clkSync;      // R11 R13
      gainData        <= dataSync;     // R13
    end
  end
endmodule

//--- emb_pkg.sv
// Package for the exciter module-bus slave and its controller end.
// Assumes a 125 MHz system clock on both ends.
package emb_pkg;
  localparam int          CLK_HZ        = 125000000;
  localparam int          LINK_KHZ      = 625;
  // Half period of the 625 kHz shift clock, in system cycles
  localparam int          LINK_HALF_CYC = CLK_HZ / (LINK_KHZ * 1000 * 2);
  localparam int          FRAME_BITS    = 32;
  localparam int          STATUS_BITS   = 8;
  localparam logic [3:0]  ADDR_EXCITER  = 4'h5;
  localparam logic [3:0]  ADDR_GAIN     = 4'h9;
  localparam logic [3:0]  ADDR_IDLE     = 4'h0;
  localparam int          LOOPBACK_POS  = 31;
  localparam int          METER_SEL_POS = 15;
  localparam int          KEYED_MODE_POS = 24;
  localparam int          LPF_BYPASS_POS = 25;
  localparam int          LPF_BAND_LO    = 26;
  localparam int          LPF_BAND_HI    = 28;
  localparam int          LPF_TEST_POS   = 29;
  localparam int          POWERUP_MS    = 400;
  localparam int          POWERUP_CYC   = POWERUP_MS * (CLK_HZ / 1000);
  localparam logic [31:0] CMD_RESET     = 32'h0000_0000;
  localparam int          STROBE_CYC    = 4;
endpackage

//--- exciter_module_bus_interface_test.sv
// Bench: controller and exciter joined over the module control bus.
// Assumes emb_pkg, emb_bus_if and both ends compiled first.
`timescale 1ns/10ps
module exciter_module_bus_interface_test;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        writeReq = 1'b0;
  logic        readReq = 1'b0;
  logic [3:0]  targetAddress = 4'h0;
  logic [31:0] frameIn = 32'h0;
  logic [6:0]  statusHigh = 7'h00;
  logic [7:0]  statusIn;
  logic [31:0] commandOut;
  logic [2:0]  lpfBandSelect;
  logic [7:0]  statusWord;
  logic        outputEnable, meterPathSelect, keyedModeLine, lpfBypass, lpfTestEnable, loopBackBit;
  logic        gainWriteStrobe, gainClock, gainData, busy, readDone, loopBackOk;
  integer      failures = 0, samplesChecked = 0, seed = 19888, gainStrobes = 0, gainEdges = 0;
  integer      readDones = 0;
  logic        gainClkQ = 1'b0;
  logic [31:0] gainShift = 32'h0;

  emb_bus_if bus ();
  // Loop-back rides back in the lowest status bit
  assign statusIn = {statusHigh, loopBackBit};
  always #4 clock = ~clock;
  always @(posedge gainWriteStrobe) gainStrobes++;
  always @(posedge gainClock) gainEdges++;
  always @(posedge readDone) readDones++;
  // Old values seen at the edge, so data is taken with its clock rise
  always @(posedge clock) begin
    gainClkQ <= gainClock;
    if (gainClock && !gainClkQ)
      gainShift <= {gainShift[30:0], gainData};
  end

  emb_exciter #(.POWERUP_CYCLES(100)) i_emb_exciter (.clock(clock), .rst(rst), .bus(bus), .statusIn(statusIn),
    .commandOut(commandOut), .outputEnable(outputEnable), .meterPathSelect(meterPathSelect),
    .keyedModeLine(keyedModeLine), .lpfBypass(lpfBypass), .lpfBandSelect(lpfBandSelect),
    .lpfTestEnable(lpfTestEnable), .loopBackBit(loopBackBit), .gainWriteStrobe(gainWriteStrobe),
    .gainClock(gainClock), .gainData(gainData));
  emb_controller i_emb_controller (.clock(clock), .rst(rst), .bus(bus), .writeReq(writeReq), .readReq(readReq),
    .targetAddress(targetAddress), .frameIn(frameIn), .busy(busy), .readDone(readDone),
    .statusWord(statusWord), .loopBackOk(loopBackOk));
  emb_bus_checker i_emb_bus_checker (.clock(clock), .rst(rst), .moduleAddress(bus.moduleAddress),
    .busClock(bus.busClock), .serialData(bus.serialData), .writeCmd(bus.writeCmd), .readCmd(bus.readCmd),
    .returnOut(bus.returnOut), .returnOe(bus.returnOe));

  function automatic logic [31:0] fieldOf(input logic [31:0] f, input int pos, input int w);
    return (f >> pos) & ((32'h1 << w) - 32'h1);
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic busOp(input logic wr, input logic [3:0] addr, input logic [31:0] frame);
    integer n;
    n = 0;
    @(posedge clock);
    #1;
    writeReq = wr;
    readReq = !wr;
    targetAddress = addr;
    frameIn = frame;
    @(posedge clock);
    #1;
    writeReq = 1'b0;
    readReq = 1'b0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("busy", 32'h0, {31'h0, busy});
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #760000;
    failures++;
    report_and_stop();
  end

  initial begin
    logic [31:0] f;
    logic [3:0]  other [3];
    integer      n0, e0, r0;
    other = '{emb_pkg::ADDR_GAIN, 4'h3, 4'hd};
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    repeat (90) @(posedge clock);
    check("enable", 32'h0, {31'h0, outputEnable});
    repeat (30) @(posedge clock);
    check("enable", 32'h1, {31'h0, outputEnable});
    for (int i = 0; i < 7; i++) begin
      f = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h0000_0001 : (i == 2) ? 32'hffff_ffff : $random(seed);
      busOp(1'b1, emb_pkg::ADDR_EXCITER, f);
      check("command", f, commandOut);
      check("loopBack", fieldOf(f, emb_pkg::LOOPBACK_POS, 1), {31'h0, loopBackBit});
      check("meterPath", fieldOf(f, emb_pkg::METER_SEL_POS, 1), {31'h0, meterPathSelect});
      check("offBoard", fieldOf(f, 24, 6), {26'h0, lpfTestEnable, lpfBandSelect, lpfBypass, keyedModeLine});
      statusHigh = $random(seed);
      r0 = readDones;
      busOp(1'b0, emb_pkg::ADDR_EXCITER, 32'h0);
      check("readDone", 32'h1, readDones - r0);
      check("status", {24'h0, statusHigh, f[31]}, {24'h0, statusWord});
      check("loopBackOk", {31'h0, f[31]}, {31'h0, loopBackOk});
      check("hold", f, commandOut);
    end
    for (int i = 0; i < 3; i++) begin
      n0 = gainStrobes;
      e0 = gainEdges;
      busOp(1'b1, other[i], ~f);
      check("unchanged", f, commandOut);
      check("gainStrobe", (i == 0), gainStrobes - n0);
      check("gainClock", 32'h20, gainEdges - e0);
      check("gainData", ~f, gainShift);
    end
    r0 = readDones;
    busOp(1'b0, emb_pkg::ADDR_GAIN, 32'h0);
    check("afterGainRead", f, commandOut);
    check("gainStatus", 32'h0, {24'h0, statusWord});
    check("gainReadDone", 32'h1, readDones - r0);
    report_and_stop();
  end
endmodule
